// ==== src/cspsp_core.sv ====
// scan-out addressing: smooth scroll, pel pan, origin, split screen, retrace irq
`timescale 1ns/100ps
`default_nettype none
module cspsp_core #(
  parameter int H_TOTAL = 100,
  parameter int H_VISIBLE = 80,
  parameter int V_TOTAL = 449,
  parameter int V_VISIBLE = 400,
  parameter int CELL_H = 16,
  parameter int ROW_WORDS = 80
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic irq_o,
  output logic vretrace_o,
  output logic disp_en_o,
  output cspsp_pkg::cspsp_fetch_t fetch_o
);
  ////////////////////////////////////////////////////////////////////////
  // refuse timing that the counters cannot hold
  if (CELL_H < 2 || CELL_H > 32) begin : g_cell_chk
    $error("cspsp_core: cell height out of range");
  end
  if (H_VISIBLE < 1 || H_VISIBLE >= H_TOTAL || H_TOTAL > 128) begin : g_h_chk
    $error("cspsp_core: horizontal timing out of range");
  end
  if (V_VISIBLE < 1 || V_VISIBLE >= V_TOTAL || V_TOTAL > 1023) begin : g_v_chk
    $error("cspsp_core: vertical timing out of range");
  end
  if (ROW_WORDS < 1 || ROW_WORDS > 255) begin : g_row_chk
    $error("cspsp_core: row width out of range");
  end

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdat;
    logic [15:0] origin;
    logic [4:0] row_scan;
    logic [7:0] split_lo;
    logic [7:0] overflow;
    logic [7:0] retrace_end;
    logic [7:0] attr_index;
    logic [3:0] pel_pan;
    logic [2:0] status;
    logic [2:0] mask;
    logic irq;
    cspsp_pkg::cspsp_view_t view;
    logic [9:0] split_line;
    logic [6:0] hcnt;
    logic [9:0] vcnt;
    logic [4:0] row;
    logic [15:0] row_base;
    logic split;
    logic vret;
    logic den;
    cspsp_pkg::cspsp_fetch_t fetch;
  } cspsp_state_t;

  cspsp_state_t s_r, s_nxt;

  function automatic logic wb_hit(input logic [5:0] adr, input logic [3:0] idx);
    wb_hit = (adr[5:2] == idx);
  endfunction

  logic req;
  logic wr;
  logic [7:0] wbyte;
  logic line_end;
  logic frame_end;
  logic [9:0] split_full;
  assign req = wb_cyc_i && wb_stb_i && !s_r.ack && !s_r.err;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];
  assign line_end = (32'(s_r.hcnt) == H_TOTAL - 1);
  assign frame_end = line_end && (32'(s_r.vcnt) == V_TOTAL - 1);
  assign split_full = {1'b0, s_r.overflow[cspsp_pkg::OVF_SPLIT_BIT], s_r.split_lo};

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [2:0] ev;
    logic known;
    ev = 3'h0;
    known = 1'b1;
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.err = 1'b0;
    // bus slave
    if (req) begin
      s_nxt.rdat = 32'h0;
      if (wb_hit(wb_adr_i, cspsp_pkg::ADR_ORIGIN_LOW)) begin
        s_nxt.rdat = {24'h0, s_r.origin[7:0]};
        if (wr) s_nxt.origin[7:0] = wbyte;
      end else if (wb_hit(wb_adr_i, cspsp_pkg::ADR_ORIGIN_HIGH)) begin
        s_nxt.rdat = {24'h0, s_r.origin[15:8]};
        if (wr) s_nxt.origin[15:8] = wbyte;
      end else if (wb_hit(wb_adr_i, cspsp_pkg::ADR_ROW_SCAN)) begin
        s_nxt.rdat = {27'h0, s_r.row_scan};
        if (wr) s_nxt.row_scan = wbyte[4:0];
      end else if (wb_hit(wb_adr_i, cspsp_pkg::ADR_SPLIT_LINE)) begin
        s_nxt.rdat = {24'h0, s_r.split_lo};
        if (wr) s_nxt.split_lo = wbyte;
      end else if (wb_hit(wb_adr_i, cspsp_pkg::ADR_OVERFLOW)) begin
        s_nxt.rdat = {24'h0, s_r.overflow};
        if (wr) s_nxt.overflow = wbyte;
      end else if (wb_hit(wb_adr_i, cspsp_pkg::ADR_RETRACE_END)) begin
        s_nxt.rdat = {24'h0, s_r.retrace_end};
        if (wr) s_nxt.retrace_end = wbyte;
      end else if (wb_hit(wb_adr_i, cspsp_pkg::ADR_ATTR_INDEX)) begin
        s_nxt.rdat = {24'h0, s_r.attr_index};
        if (wr) s_nxt.attr_index = wbyte;
      end else if (wb_hit(wb_adr_i, cspsp_pkg::ADR_PEL_PAN)) begin
        s_nxt.rdat = {28'h0, s_r.pel_pan};
        if (wr) s_nxt.pel_pan = wbyte[3:0];
      end else if (wb_hit(wb_adr_i, cspsp_pkg::ADR_IRQ_STATUS)) begin
        s_nxt.rdat = {29'h0, s_r.status};
        if (!wb_we_i) s_nxt.status = 3'h0;
      end else if (wb_hit(wb_adr_i, cspsp_pkg::ADR_IRQ_MASK)) begin
        s_nxt.rdat = {29'h0, s_r.mask};
        if (wr) s_nxt.mask = wbyte[2:0];
      end else if (wb_hit(wb_adr_i, cspsp_pkg::ADR_SCAN_POS)) begin
        s_nxt.rdat = {6'h0, s_r.row, s_r.split, s_r.vret, s_r.den, 8'h0, s_r.vcnt};
      end else begin
        known = 1'b0;
      end
      s_nxt.ack = known;
      s_nxt.err = !known;
    end
    ////////////////////////////////////////////////////////////////////////
    // raster counters
    s_nxt.hcnt = line_end ? 7'h0 : s_r.hcnt + 7'h1;
    if (line_end) begin
      s_nxt.vcnt = frame_end ? 10'h0 : s_r.vcnt + 10'h1;
      if (frame_end) begin
        // shadow copy taken only at frame start
        s_nxt.view.origin = s_r.origin;
        s_nxt.view.row_scan = s_r.row_scan;
        s_nxt.view.pel_pan = s_r.pel_pan;
        s_nxt.split_line = split_full;
        s_nxt.row = s_r.row_scan;
        s_nxt.row_base = s_r.origin;
        s_nxt.split = 1'b0;
        ev[cspsp_pkg::ST_FRAME_BIT] = 1'b1;
      end else if (s_r.vcnt == s_r.split_line) begin
        s_nxt.row = 5'h0;
        s_nxt.row_base = 16'h0;
        s_nxt.split = 1'b1;
        ev[cspsp_pkg::ST_SPLIT_BIT] = 1'b1;
      end else if (32'(s_r.row) >= CELL_H - 1) begin
        s_nxt.row = 5'h0;
        s_nxt.row_base = s_r.row_base + 16'(ROW_WORDS);
      end else begin
        s_nxt.row = s_r.row + 5'h1;
      end
    end
    s_nxt.vret = (32'(s_nxt.vcnt) >= V_VISIBLE);
    s_nxt.den = (32'(s_nxt.hcnt) < H_VISIBLE) && !s_nxt.vret;
    if (s_nxt.vret && !s_r.vret) ev[cspsp_pkg::ST_RETRACE_BIT] = 1'b1;
    // fetch address; pan applies to both regions
    s_nxt.fetch.addr = s_nxt.row_base + 16'(s_nxt.hcnt);
    s_nxt.fetch.row = s_nxt.row;
    s_nxt.fetch.pan = s_nxt.view.pel_pan;
    s_nxt.fetch.split = s_nxt.split;
    ////////////////////////////////////////////////////////////////////////
    // retrace flip-flop: clear-low holds it off, set wins otherwise
    if (!s_nxt.retrace_end[cspsp_pkg::RE_CLEAR_N_BIT]) s_nxt.irq = 1'b0;
    else if (ev[cspsp_pkg::ST_RETRACE_BIT]) s_nxt.irq = 1'b1;
    s_nxt.status = s_nxt.status | ev;
    s_nxt.irq = s_nxt.irq;
  end

  logic irq_line_nxt;
  logic irq_line_r;
  assign irq_line_nxt = (s_nxt.irq && s_nxt.retrace_end[cspsp_pkg::RE_IRQ_ENABLE_BIT]) ||
                        |(s_nxt.status & s_nxt.mask);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.overflow <= cspsp_pkg::OVERFLOW_RST;
      s_r.retrace_end <= cspsp_pkg::RETRACE_END_RST;
      s_r.split_lo <= cspsp_pkg::SPLIT_LINE_RST[7:0];
      s_r.split_line <= cspsp_pkg::SPLIT_LINE_RST;
      irq_line_r <= 1'b0;
    end else begin
      s_r <= s_nxt;
      irq_line_r <= irq_line_nxt;
    end
  end

  assign wb_dat_o = s_r.rdat;
  assign wb_ack_o = s_r.ack;
  assign wb_err_o = s_r.err;
  assign irq_o = irq_line_r;
  assign vretrace_o = s_r.vret;
  assign disp_en_o = s_r.den;
  assign fetch_o = s_r.fetch;

  ////////////////////////////////////////////////////////////////////////
  sequence split_hit_s;
    line_end && !frame_end && s_r.vcnt == s_r.split_line;
  endsequence

  split_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    split_hit_s |=> s_r.row == 5'h0 && s_r.split)
    else $error("row counter not cleared at split line");
  split_base_a: assert property (@(posedge clk_i) disable iff (rst_i)
    split_hit_s |=> s_r.row_base == 16'h0)
    else $error("split region not fetched from zero");
  frame_row_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_end |=> s_r.row == $past(s_r.row_scan))
    else $error("frame not started at preset row");
  frame_base_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_end |=> s_r.row_base == $past(s_r.origin))
    else $error("frame not started at origin");
  view_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(frame_end) |-> $stable(s_r.view))
    else $error("scroll values changed mid-frame");
  split_ovf_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_end |=> s_r.split_line[8] == $past(s_r.overflow[cspsp_pkg::OVF_SPLIT_BIT]))
    else $error("split ninth bit not from overflow");
  irq_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_r.retrace_end[cspsp_pkg::RE_CLEAR_N_BIT] |-> !s_r.irq)
    else $error("retrace flip-flop set while held clear");
  irq_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.retrace_end[cspsp_pkg::RE_CLEAR_N_BIT] && !s_r.vret ##1
    s_r.vret && s_r.retrace_end[cspsp_pkg::RE_CLEAR_N_BIT] |-> s_r.irq)
    else $error("retrace did not set flip-flop");
  row_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    line_end && !frame_end && s_r.vcnt != s_r.split_line && 32'(s_r.row) == CELL_H - 1
    |=> s_r.row == 5'h0)
    else $error("row did not wrap at cell height");
  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.ack |=> !s_r.ack)
    else $error("ack held over two cycles");

  ////////////////////////////////////////////////////////////////////////
  // latch, fetch, raster and origin write checks
  sequence frame_start_s;
    frame_end;
  endsequence

  sequence retrace_rise_s;
    !s_r.vret ##1 s_r.vret;
  endsequence

  pan_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_start_s |=> s_r.fetch.pan == $past(s_r.pel_pan))
    else $error("pel pan not latched at frame start");
  fetch_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.den |-> s_r.fetch.addr == s_r.row_base + 16'(s_r.hcnt))
    else $error("fetch address not row base plus column");
  row_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    line_end && !frame_end && s_r.vcnt != s_r.split_line && 32'(s_r.row) < CELL_H - 1
    |=> s_r.row == $past(s_r.row) + 5'h1)
    else $error("row did not step by one line");
  vret_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.vret == (32'(s_r.vcnt) >= V_VISIBLE))
    else $error("retrace level does not follow line count");
  origin_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_hit(wb_adr_i, cspsp_pkg::ADR_ORIGIN_LOW) |=> s_r.origin[7:0] == $past(wbyte))
    else $error("origin low byte not written");
  ////////////////////////////////////////////////////////////////////////
  // interrupt and bus checks
  irq_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.irq && s_r.retrace_end[cspsp_pkg::RE_IRQ_ENABLE_BIT] |-> irq_o)
    else $error("enabled retrace flip-flop not on irq");
  irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_r.retrace_end[cspsp_pkg::RE_IRQ_ENABLE_BIT] && (s_r.status & s_r.mask) == 3'h0 |-> !irq_o)
    else $error("irq raised while disabled");
  retrace_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    retrace_rise_s |-> s_r.status[cspsp_pkg::ST_RETRACE_BIT])
    else $error("retrace status not set");
  split_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    split_hit_s |=> s_r.status[cspsp_pkg::ST_SPLIT_BIT])
    else $error("split status not set");
  err_unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_adr_i[5:2] > cspsp_pkg::ADR_SCAN_POS |=> s_r.err && !s_r.ack)
    else $error("unmapped access not refused");
  ack_mapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !(wb_adr_i[5:2] > cspsp_pkg::ADR_SCAN_POS) |=> s_r.ack && !s_r.err)
    else $error("mapped access not acknowledged");
endmodule
`default_nettype wire

// ==== src/cspsp_pkg.sv ====
// package: register offsets, fields, structs for the scan-out address block
package cspsp_pkg;
  localparam logic [3:0] ADR_ORIGIN_LOW = 4'h0;
  localparam logic [3:0] ADR_ORIGIN_HIGH = 4'h1;
  localparam logic [3:0] ADR_ROW_SCAN = 4'h2;
  localparam logic [3:0] ADR_SPLIT_LINE = 4'h3;
  localparam logic [3:0] ADR_OVERFLOW = 4'h4;
  localparam logic [3:0] ADR_RETRACE_END = 4'h5;
  localparam logic [3:0] ADR_ATTR_INDEX = 4'h6;
  localparam logic [3:0] ADR_PEL_PAN = 4'h7;
  localparam logic [3:0] ADR_IRQ_STATUS = 4'h8;
  localparam logic [3:0] ADR_IRQ_MASK = 4'h9;
  localparam logic [3:0] ADR_SCAN_POS = 4'ha;
  localparam int OVF_SPLIT_BIT = 4;
  localparam int RE_IRQ_ENABLE_BIT = 5;
  localparam int RE_CLEAR_N_BIT = 4;
  localparam int ATTR_PAL_EN_BIT = 5;
  localparam logic [4:0] PEL_PAN_INDEX = 5'h13;
  localparam logic [7:0] OVERFLOW_RST = 8'h00;
  localparam logic [7:0] RETRACE_END_RST = 8'h00;
  localparam logic [9:0] SPLIT_LINE_RST = 10'h3ff;
  localparam logic [4:0] ROW_SCAN_MAX = 5'h0d;
  localparam int ST_FRAME_BIT = 0;
  localparam int ST_SPLIT_BIT = 1;
  localparam int ST_RETRACE_BIT = 2;

  typedef struct packed {
    logic [15:0] origin;
    logic [4:0] row_scan;
    logic [3:0] pel_pan;
  } cspsp_view_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [4:0] row;
    logic [3:0] pan;
    logic split;
  } cspsp_fetch_t;
endpackage

// ==== bench/cspsp_host.sv ====
// wishbone host model for the scan-out block register bus
`timescale 1ns/100ps
`default_nettype none
module cspsp_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic err_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [5:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  logic got_err;
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 6'h00;
    sel_o = 4'h0;
    dat_o = 32'h00000000;
    got_err = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // one classic cycle, held until ack or err is sampled
  task automatic xfer(input logic w, input logic [3:0] i, input logic [7:0] d,
                      output logic [31:0] q);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= {i, 2'b00};
    sel_o <= 4'h1;
    dat_o <= {24'h000000, d};
    @(posedge clk_i);
    while (ack_i !== 1'b1 && err_i !== 1'b1) @(posedge clk_i);
    q = dat_i;
    got_err = err_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~dat_o;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ==== bench/crtc_scroll_pan_split_tb.sv ====
// self-checking bench for the scan-out addressing block
`timescale 1ns/100ps
`default_nettype none
module crtc_scroll_pan_split_tb;
  localparam int CH = 16;
  localparam int RW = 80;
  localparam int HV = 16;
  localparam int VV = 20;
  logic clk_i, rst_i, cyc, stb, we, ack, err, irq, vret, den;
  logic [5:0] adr;
  logic [3:0] sel;
  logic [31:0] dwr, drd, q;
  cspsp_pkg::cspsp_fetch_t fet;
  logic [7:0] mdl [16];
  int num_errors, compares;
  cspsp_core #(.H_TOTAL(20), .H_VISIBLE(HV), .V_TOTAL(30), .V_VISIBLE(VV)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack),
    .wb_err_o(err), .irq_o(irq), .vretrace_o(vret), .disp_en_o(den), .fetch_o(fet));
  cspsp_host host (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(drd), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dwr));
  ////////////////////////////////////////////////////////////
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_fetch(input cspsp_pkg::cspsp_fetch_t g, input cspsp_pkg::cspsp_fetch_t e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    host.xfer(1'b1, i, d, q);
    mdl[i] = d;
  endtask
  task automatic next_retrace;
    while (vret !== 1'b0) @(posedge clk_i);
    while (vret !== 1'b1) @(posedge clk_i);
  endtask
  // every visible line of the next frame against the model, sampled mid-cycle
  task automatic frame_chk;
    int s, rs, n;
    cspsp_pkg::cspsp_fetch_t e;
    s = {mdl[4][4], mdl[3]};
    rs = int'(mdl[2]);
    while (vret !== 1'b0) @(negedge clk_i);
    for (int ln = 0; ln < VV; ln++) begin
      while (den !== 1'b1) @(negedge clk_i);
      // split region starts on the line after the compare match
      e.split = ln > s;
      e.addr = e.split ? 16'(((ln - s - 1) / CH) * RW) :
               {mdl[1], mdl[0]} + 16'(((rs + ln) / CH) * RW);
      e.row = e.split ? 5'((ln - s - 1) % CH) : 5'((rs + ln) % CH);
      e.pan = mdl[7][3:0];
      chk_fetch(fet, e);
      n = 0;
      while (den !== 1'b0) begin
        n++;
        @(negedge clk_i);
      end
      chk_reg(32'(n), 32'(HV));
    end
    @(posedge clk_i);
  endtask
  task automatic pass(input logic [4:0] rs, input logic [7:0] ovf, input logic [7:0] msk);
    next_retrace();
    wr(cspsp_pkg::ADR_ORIGIN_LOW, 8'($urandom));
    wr(cspsp_pkg::ADR_ORIGIN_HIGH, 8'($urandom));
    wr(cspsp_pkg::ADR_ROW_SCAN, {3'h0, rs});
    wr(cspsp_pkg::ADR_PEL_PAN, 8'($urandom % 16));
    wr(cspsp_pkg::ADR_SPLIT_LINE, 8'h0c);
    wr(cspsp_pkg::ADR_OVERFLOW, ovf);
    wr(cspsp_pkg::ADR_IRQ_MASK, msk);
    for (int i = 0; i < 10; i++) begin
      if (i != 8) begin
        host.xfer(1'b0, 4'(i), 8'h00, q);
        chk_reg(q, {24'h000000, mdl[i]});
      end
    end
    frame_chk();
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'he5d36e83));
    rst_i = 1'b1;
    num_errors = 0;
    compares = 0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[3] = 8'hff;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) begin
      host.xfer(1'b0, 4'(i), 8'h00, q);
      chk_reg(q, {24'h000000, mdl[i]});
    end
    host.xfer(1'b1, 4'hb, 8'h5a, q);
    chk_reg({31'h0, host.got_err}, 32'h1);
    wr(cspsp_pkg::ADR_ATTR_INDEX, 8'h20 | 8'(cspsp_pkg::PEL_PAN_INDEX));
    pass(5'h00, 8'h10, 8'h00);
    pass(5'(1 + $urandom % 13), 8'h10, 8'h00);
    pass(5'(1 + $urandom % 13), 8'h00, 8'h02);
    chk_reg({31'h0, irq}, 32'h1);
    host.xfer(1'b0, cspsp_pkg::ADR_IRQ_STATUS, 8'h00, q);
    chk_reg(q & 32'h2, 32'h2);
    repeat (2) @(posedge clk_i);
    chk_reg({31'h0, irq}, 32'h0);
    wr(cspsp_pkg::ADR_IRQ_MASK, 8'h00);
    wr(cspsp_pkg::ADR_RETRACE_END, 8'h30);
    next_retrace();
    repeat (3) @(posedge clk_i);
    chk_reg({31'h0, irq}, 32'h1);
    chk_reg({31'h0, vret}, 32'h1);
    host.xfer(1'b0, cspsp_pkg::ADR_SCAN_POS, 8'h00, q);
    chk_reg(q & 32'h000c0000, 32'h00080000);
    wr(cspsp_pkg::ADR_RETRACE_END, 8'h20);
    repeat (2) @(posedge clk_i);
    chk_reg({31'h0, irq}, 32'h0);
    wr(cspsp_pkg::ADR_RETRACE_END, 8'h10);
    next_retrace();
    repeat (3) @(posedge clk_i);
    chk_reg({31'h0, irq}, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
